// ---- fcp_cfg.svh ----
`ifndef FCP_CFG_SVH
`define FCP_CFG_SVH
`define FCP_LAST_MEM_REG   6'd54
`define FCP_LAST_ALU_DEST  6'd47
`define FCP_CONST_ZERO     6'd52
`define FCP_CONST_HALF     6'd53
`define FCP_CONST_ONE      6'd54
`define FCP_VAL_ZERO       64'h0000000000000000
`define FCP_VAL_HALF       64'h3fe0000000000000
`define FCP_VAL_ONE        64'h3ff0000000000000
`define FCP_ALU_LATENCY    3
`define FCP_NREGS          55
`endif

// ---- fcp_pkg.sv ----
package fcp_pkg;
   typedef enum logic [1:0] {
      FCP_UNIT_RSVD = 2'b00,
      FCP_UNIT_ADD  = 2'b01,
      FCP_UNIT_MUL  = 2'b10,
      FCP_UNIT_RCP  = 2'b11
   } fcp_unit_e;
   typedef enum logic [3:0] {
      FCP_OP_NONE  = 4'h0,
      FCP_OP_ADD   = 4'h1,
      FCP_OP_SUB   = 4'h2,
      FCP_OP_FLOAT = 4'h3,
      FCP_OP_TRUNC = 4'h4,
      FCP_OP_FMUL  = 4'h5,
      FCP_OP_IMUL  = 4'h6,
      FCP_OP_ITER  = 4'h7,
      FCP_OP_RECIP = 4'h8
   } fcp_op_e;
   // ALU instruction word as it arrives on the address lines.
   typedef struct packed {
      logic [5:0] dest;
      logic [5:0] src_a_spec;
      logic [5:0] src_b_spec;
      logic [3:0] length;
      logic       sca;
      logic       scb;
      logic [1:0] unit;
      logic [1:0] func;
      logic [3:0] spare;
   } fcp_alu_instr_s;
   // Issued element handed to the arithmetic datapath.
   typedef struct packed {
      logic        valid;
      fcp_op_e     op;
      logic [5:0]  dest;
      logic        writes;
      logic [63:0] opnd_a;
      logic [63:0] opnd_b;
   } fcp_issue_s;
endpackage

// ---- fcp_issue_port.sv ----
`timescale 1ns/1ps
`include "fcp_cfg.svh"
//==============================================================
// Summary of operation
// - Load writes aligned doubleword to registers 0..54.
// - Store drives full register for specifiers 0..54.
// - Hold writeback_advance low while source is pending.
// - CPU-to-FPU transfer loads only upper half.
// - Transfer-in data captured one stage after loads.
// - FPU-to-CPU transfer drives upper half on word one.
// - Transfer-out data driven one stage before stores.
// - Execute ALU instruction only for destination 0..47.
// - Static length field gives 1 to 16 elements.
// - Zero length clears, else decrement, increment, reissue.
// - Scalar bits freeze the matching source specifiers.
// - Every element passes the scoreboard checks.
// - Unit field: reserved, adder, multiplier, reciprocal.
// - Adder functions: add, subtract, float, trunc.
// - Multiplier functions: multiply, imul, iteration, reserved.
// - Reciprocal function zero only; others reserved.
// - Claim by destination or source as instruction class.
// - Specifiers 52..54 read constants as ALU sources; ALU writes ignored.
//==============================================================
module fcp_issue_port (
   input  wire logic                   core_clk,
   input  wire logic                   reset,
   // Memory-port command presented in the CPU ALU stage.
   input  wire logic                   mem_cmd_valid,
   input  wire logic [1:0]             mem_cmd_kind,
   input  wire logic [5:0]             mem_coproc_reg_spec,
   // Data bus, word one is the upper half.
   input  wire logic [63:0]            data_in,
   output logic      [63:0]            data_out,
   output logic                        data_out_en,
   output logic                        writeback_advance,
   // ALU instruction word, valid at the start of MEM.
   input  wire logic                   alu_instr_valid,
   input  wire fcp_pkg::fcp_alu_instr_s alu_instr,
   // Result write-back from the datapath.
   input  wire logic                   result_valid,
   input  wire logic [5:0]             result_dest,
   input  wire logic [63:0]            result_data,
   output fcp_pkg::fcp_issue_s         issue,
   output logic                        alu_busy
);
   // Command kinds: 0 load, 1 store, 2 CPU-to-FPU, 3 FPU-to-CPU.
   localparam logic [1:0] K_LOAD = 2'd0;
   localparam logic [1:0] K_STORE = 2'd1;
   localparam logic [1:0] K_XIN  = 2'd2;
   localparam logic [1:0] K_XOUT = 2'd3;

   //==============================================================
   // Register file and scoreboard.
   // One pending bit per specifier is set when an element that writes is
   // issued and cleared when its result comes back. Reads of the memory
   // port and sources of later elements both wait on these bits.
   // The contents are not reset; software must load a register before use.
   logic [63:0] regs [0:`FCP_NREGS-1];
   logic [63:0] regs_next [0:`FCP_NREGS-1];
   logic [63:0] pend_reg, pend_next;

   //==============================================================
   // Pipeline of memory-port commands: MEM then WB stage.
   logic        mem_v_reg, mem_v_next, wb_v_reg, wb_v_next;
   logic [1:0]  mem_k_reg, mem_k_next, wb_k_reg, wb_k_next;
   logic [5:0]  mem_s_reg, mem_s_next, wb_s_reg, wb_s_next;
   logic [63:0] dout_reg, dout_next;
   logic        den_reg, den_next, wba_reg, wba_next;

   //==============================================================
   // Vector issue register.
   fcp_pkg::fcp_alu_instr_s ir_reg, ir_next;
   logic                    ir_v_reg, ir_v_next;
   fcp_pkg::fcp_issue_s     iss_reg, iss_next;

   //==============================================================
   // Operand read and decode helpers.
   // The three top specifiers stand for constants only when an ALU element
   // reads them; the memory port still sees the stored words there.
   function automatic logic [63:0] alu_read(input logic [5:0] s, input logic [63:0] v);
      unique case (s)
         `FCP_CONST_ZERO: alu_read = `FCP_VAL_ZERO;
         `FCP_CONST_HALF: alu_read = `FCP_VAL_HALF;
         `FCP_CONST_ONE:  alu_read = `FCP_VAL_ONE;
         default:         alu_read = v;
      endcase
   endfunction

   // Reserved unit and function codes fold onto one code that never writes,
   // so that the datapath needs no separate reserved check.
   function automatic fcp_pkg::fcp_op_e decode(input logic [1:0] u, input logic [1:0] f);
      decode = fcp_pkg::FCP_OP_NONE;
      unique case (fcp_pkg::fcp_unit_e'(u))
         fcp_pkg::FCP_UNIT_RSVD: decode = fcp_pkg::FCP_OP_NONE;
         fcp_pkg::FCP_UNIT_ADD:
            unique case (f)
               2'd0: decode = fcp_pkg::FCP_OP_ADD;
               2'd1: decode = fcp_pkg::FCP_OP_SUB;
               2'd2: decode = fcp_pkg::FCP_OP_FLOAT;
               2'd3: decode = fcp_pkg::FCP_OP_TRUNC;
            endcase
         fcp_pkg::FCP_UNIT_MUL:
            unique case (f)
               2'd0: decode = fcp_pkg::FCP_OP_FMUL;
               2'd1: decode = fcp_pkg::FCP_OP_IMUL;
               2'd2: decode = fcp_pkg::FCP_OP_ITER;
               2'd3: decode = fcp_pkg::FCP_OP_NONE;
            endcase
         fcp_pkg::FCP_UNIT_RCP:
            decode = (f == 2'd0) ? fcp_pkg::FCP_OP_RECIP : fcp_pkg::FCP_OP_NONE;
      endcase
   endfunction

   logic mem_claim, src_a_busy, src_b_busy, dst_busy, elem_ok;
   logic xout_wait, store_wait, port_stall;
   fcp_pkg::fcp_op_e cur_op;

   //==============================================================
   // Memory-port pipeline.
   // A command sits in MEM for the cycle after it is taken and in WB for
   // the cycle after that. A transfer out drives its word from MEM and a
   // store drives its doubleword from WB, so the transfer is a stage early.
   // A stall freezes both stages together, so that nothing behind a read
   // that waits for its data can overtake it.
   // The CPU must not place a store and a transfer out so that both would
   // drive in one cycle; should it do so, the store wins the bus.
   always_comb begin
      // Loads and transfers in claim by destination, the others by source.
      // Both arrive in the one specifier field, so one range test serves.
      mem_claim = mem_cmd_valid && (mem_coproc_reg_spec <= `FCP_LAST_MEM_REG);
      xout_wait = mem_v_reg && (mem_k_reg == K_XOUT) && pend_reg[mem_s_reg];
      store_wait = wb_v_reg && (wb_k_reg == K_STORE) && pend_reg[wb_s_reg];
      port_stall = xout_wait || store_wait;
      if (port_stall) begin
         mem_v_next = mem_v_reg;
         mem_k_next = mem_k_reg;
         mem_s_next = mem_s_reg;
         wb_v_next = wb_v_reg;
         wb_k_next = wb_k_reg;
         wb_s_next = wb_s_reg;
      end else begin
         mem_v_next = mem_claim;
         mem_k_next = mem_cmd_kind;
         mem_s_next = mem_coproc_reg_spec;
         wb_v_next = mem_v_reg;
         wb_k_next = mem_k_reg;
         wb_s_next = mem_s_reg;
      end
      // The advance flag is registered with the data, so it is low in every
      // cycle in which the data that the CPU waits for is not on the bus.
      wba_next = !port_stall;
      den_next = 1'b0;
      dout_next = 64'h0;
      if (!port_stall) begin
         if (mem_v_reg && mem_k_reg == K_XOUT) begin
            den_next = 1'b1;
            dout_next = {regs[mem_s_reg][63:32], 32'h0};
         end
         if (wb_v_reg && wb_k_reg == K_STORE) begin
            den_next = 1'b1;
            dout_next = regs[wb_s_reg];
         end
      end
   end

   always_comb begin
      for (int i = 0; i < `FCP_NREGS; i++) begin
         regs_next[i] = regs[i];
      end
      pend_next = pend_reg;
      if (result_valid) begin
         regs_next[result_dest] = result_data;
         pend_next[result_dest] = 1'b0;
      end
      // Loads use the full doubleword in MEM; transfers in wait a stage to WB.
      // A frozen stage must not write again, as the bus has moved on.
      if (!port_stall && mem_v_reg && mem_k_reg == K_LOAD) begin
         regs_next[mem_s_reg] = data_in;
      end
      if (!port_stall && wb_v_reg && wb_k_reg == K_XIN) begin
         regs_next[wb_s_reg] = {data_in[63:32], 32'h0};
      end
      // Issue: each element checks the scoreboard like a scalar instruction.
      cur_op = decode(ir_reg.unit, ir_reg.func);
      src_a_busy = pend_reg[ir_reg.src_a_spec] && ir_reg.src_a_spec < `FCP_CONST_ZERO;
      src_b_busy = pend_reg[ir_reg.src_b_spec] && ir_reg.src_b_spec < `FCP_CONST_ZERO;
      dst_busy = pend_reg[ir_reg.dest];
      elem_ok = ir_v_reg && !src_a_busy && !src_b_busy && !dst_busy;
      ir_next = ir_reg;
      ir_v_next = ir_v_reg;
      iss_next = '0;
      if (elem_ok) begin
         iss_next.valid = 1'b1;
         iss_next.op = cur_op;
         iss_next.dest = ir_reg.dest;
         iss_next.writes = (cur_op != fcp_pkg::FCP_OP_NONE)
            && (ir_reg.dest < `FCP_CONST_ZERO);
         iss_next.opnd_a = alu_read(ir_reg.src_a_spec, regs[ir_reg.src_a_spec]);
         iss_next.opnd_b = alu_read(ir_reg.src_b_spec, regs[ir_reg.src_b_spec]);
         if (iss_next.writes) begin
            pend_next[ir_reg.dest] = 1'b1;
         end
         if (ir_reg.length == 4'h0) begin
            ir_v_next = 1'b0;
         end else begin
            ir_next.length = ir_reg.length - 4'h1;
            ir_next.dest = ir_reg.dest + 6'd1;
            if (!ir_reg.sca) begin
               ir_next.src_a_spec = ir_reg.src_a_spec + 6'd1;
            end
            if (!ir_reg.scb) begin
               ir_next.src_b_spec = ir_reg.src_b_spec + 6'd1;
            end
         end
      end
      // New instruction accepted only when the register is free.
      if (!ir_v_next && alu_instr_valid && alu_instr.dest <= `FCP_LAST_ALU_DEST) begin
         ir_next = alu_instr;
         ir_v_next = 1'b1;
      end
   end

   //==============================================================
   // Registers.
   // The register file keeps its contents through reset; only the
   // scoreboard is cleared, so that no stale pending bit blocks a read.
   always_ff @(posedge core_clk) begin
      regs <= regs_next;
      if (reset) begin
         pend_reg <= 64'h0;
      end else begin
         pend_reg <= pend_next;
      end
   end

   // Memory-port stages and bus outputs.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mem_v_reg <= 1'b0;
         mem_k_reg <= 2'd0;
         mem_s_reg <= 6'd0;
         wb_v_reg <= 1'b0;
         wb_k_reg <= 2'd0;
         wb_s_reg <= 6'd0;
         dout_reg <= 64'h0;
         den_reg <= 1'b0;
         wba_reg <= 1'b1;
      end else begin
         mem_v_reg <= mem_v_next;
         mem_k_reg <= mem_k_next;
         mem_s_reg <= mem_s_next;
         wb_v_reg <= wb_v_next;
         wb_k_reg <= wb_k_next;
         wb_s_reg <= wb_s_next;
         dout_reg <= dout_next;
         den_reg <= den_next;
         wba_reg <= wba_next;
      end
   end

   // Vector instruction register and issue output.
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ir_reg <= '0;
         ir_v_reg <= 1'b0;
         iss_reg <= '0;
      end else begin
         ir_reg <= ir_next;
         ir_v_reg <= ir_v_next;
         iss_reg <= iss_next;
      end
   end

   assign data_out = dout_reg;
   assign data_out_en = den_reg;
   assign writeback_advance = wba_reg;
   assign issue = iss_reg;
   assign alu_busy = ir_v_reg;
endmodule // fcp_issue_port

// ---- fcp_issue_port_chk.sv ----
`timescale 1ns/1ps
// ==========
// Port checker.
module fcp_issue_port_chk (
   input wire logic                    core_clk,
   input wire logic                    reset,
   input wire logic                    data_out_en,
   input wire logic                    writeback_advance,
   input wire logic                    alu_instr_valid,
   input wire fcp_pkg::fcp_alu_instr_s alu_instr,
   input wire fcp_pkg::fcp_issue_s     issue,
   input wire logic                    alu_busy
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   a_reset_state: assert property (disable iff (1'b0)
      reset |=> writeback_advance && !data_out_en && !issue.valid && !alu_busy)
      else $error("bad state after reset");
   a_busy_cause: assert property (
      $rose(alu_busy) |-> $past(alu_instr_valid)) else $error("busy without instruction");
   a_dest_range: assert property (
      alu_instr_valid && alu_instr.dest > 6'd47 && !alu_busy |=> !alu_busy)
      else $error("high destination accepted");
   a_const_dest: assert property (
      issue.valid && issue.dest >= 6'd52 |-> !issue.writes) else $error("constant written");
   a_rsvd_op: assert property (
      issue.valid && issue.op == fcp_pkg::FCP_OP_NONE |-> !issue.writes)
      else $error("reserved op writes");
   a_last_issue: assert property (
      $fell(alu_busy) && !$past(reset) |-> issue.valid) else $error("cleared without issue");
   a_stall_quiet: assert property (
      !writeback_advance |-> !data_out_en) else $error("data during stall");
   a_issue_busy: assert property (
      issue.valid |-> $past(alu_busy)) else $error("issue from empty register");
   a_issue_soon: assert property (
      $rose(alu_busy) |-> ##[1:60] issue.valid) else $error("no issue after load");
endmodule // fcp_issue_port_chk

bind fcp_issue_port fcp_issue_port_chk i_chk (.core_clk, .reset, .data_out_en,
   .writeback_advance, .alu_instr_valid, .alu_instr, .issue, .alu_busy);

// ---- fcp_cpu_model.sv ----
`timescale 1ns/1ps
// ==========
// Integer CPU data bus model.
module fcp_cpu_model (
   input  wire logic        core_clk,
   input  wire logic        mem_cmd_valid,
   input  wire logic [1:0]  mem_cmd_kind,
   input  wire logic [63:0] cpu_word,
   output logic      [63:0] data_in
);
   logic [63:0] w1_reg, w2_reg;
   logic [63:0] last_reg = 64'h0;
   logic        ld1_reg, xi1_reg, xi2_reg;
   always @(posedge core_clk) begin
      ld1_reg  <= mem_cmd_valid && mem_cmd_kind == 2'h0;
      xi1_reg  <= mem_cmd_valid && mem_cmd_kind == 2'h2;
      xi2_reg  <= xi1_reg;
      w1_reg   <= cpu_word;
      w2_reg   <= w1_reg;
      last_reg <= data_in;
   end
   // The CPU forms the aligned address itself; only the doubleword arrives.
   // An idle bus toggles so that a late sample never sees stale data.
   always_comb begin
      data_in = ~last_reg;
      if (ld1_reg) data_in = w1_reg;
      if (xi2_reg) data_in[63:32] = w2_reg[63:32];
   end
endmodule // fcp_cpu_model

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "fcp_cfg.svh"
// ==========
// Self-checking bench.
module tb_top;
   typedef struct packed {
      logic [1:0] k; logic [5:0] s; logic [63:0] w; logic en; logic [63:0] x;
   } fcp_row_s;
   logic                    core_clk, reset, mem_cmd_valid, data_out_en, writeback_advance;
   logic                    alu_instr_valid, result_valid, alu_busy, stalled;
   logic [1:0]              mem_cmd_kind;
   logic [5:0]              mem_coproc_reg_spec, result_dest;
   logic [63:0]             data_in, data_out, cpu_word, result_data;
   fcp_pkg::fcp_alu_instr_s alu_instr;
   fcp_pkg::fcp_issue_s     issue;
   logic [5:0]              rv_reg = 6'h0;
   logic [5:0][5:0]         rd_reg = '0;
   logic [63:0]             kv [3] = '{`FCP_VAL_ZERO, `FCP_VAL_HALF, `FCP_VAL_ONE};
   // Operation code for each unit and function, one nibble per code, code 0 lowest.
   logic [63:0]             ops = 64'h0008_0765_4321_0000;
   int                      n_fail = 0, total_checks = 0, cyc = 0, seen;
   fcp_row_s rows [9] = '{
      '{2'h0, 6'h03, 64'h0123456789abcdef, 1'b0, 64'h0},
      '{2'h1, 6'h03, 64'h0, 1'b1, 64'h0123456789abcdef},
      '{2'h2, 6'h05, 64'h89abcdef00000000, 1'b0, 64'h0},
      '{2'h1, 6'h05, 64'h0, 1'b1, 64'h89abcdef00000000},
      '{2'h3, 6'h03, 64'h0, 1'b1, 64'h0123456700000000},
      '{2'h0, 6'h36, 64'hfedcba9876543210, 1'b0, 64'h0},
      '{2'h1, 6'h36, 64'h0, 1'b1, 64'hfedcba9876543210},
      '{2'h0, 6'h37, 64'h1111111111111111, 1'b0, 64'h0},
      '{2'h1, 6'h37, 64'h0, 1'b0, 64'h0}};
   fcp_issue_port i_dut (.core_clk, .reset, .mem_cmd_valid, .mem_cmd_kind, .mem_coproc_reg_spec,
      .data_in, .data_out, .data_out_en, .writeback_advance, .alu_instr_valid, .alu_instr,
      .result_valid, .result_dest, .result_data, .issue, .alu_busy);
   fcp_cpu_model i_cpu (.core_clk, .mem_cmd_valid, .mem_cmd_kind, .cpu_word, .data_in);
   initial begin
      core_clk = 0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Slow datapath stand-in, so that a store of a fresh result has to wait.
   always @(negedge core_clk) begin
      rv_reg <= {rv_reg[4:0], issue.valid & issue.writes};
      rd_reg <= {rd_reg[4:0], issue.dest};
   end
   assign result_valid = rv_reg[5];
   assign result_dest  = rd_reg[5];
   assign result_data  = {16'hfeed, 42'h0, result_dest};
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail = n_fail + 1;
         test_done;
      end
   end
   task automatic chk(input logic [63:0] sv, input logic [63:0] ev);
      total_checks++;
      if (sv !== ev) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, sv, ev);
      end
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic mem(input logic [1:0] k, input logic [5:0] s, input logic [63:0] w);
      @(negedge core_clk);
      mem_cmd_valid = 1;
      mem_cmd_kind = k;
      mem_coproc_reg_spec = s;
      cpu_word = w;
      @(negedge core_clk);
      mem_cmd_valid = 0;
   endtask
   task automatic alu(input logic [5:0] d, a, b, input logic [3:0] n, input logic [5:0] uf);
      @(negedge core_clk);
      while (alu_busy !== 1'b0) @(negedge core_clk);
      alu_instr = '{d, a, b, n, uf[5], uf[4], uf[3:2], uf[1:0], 4'h0};
      alu_instr_valid = 1;
      @(negedge core_clk);
      alu_instr_valid = 0;
   endtask
   task automatic next_issue;
      @(negedge core_clk);
      for (seen = 0; issue.valid !== 1'b1 && seen < 40; seen++) @(negedge core_clk);
   endtask
   initial begin
      reset = 1;
      {mem_cmd_valid, mem_cmd_kind, mem_coproc_reg_spec, cpu_word} = '0;
      alu_instr_valid = 0;
      alu_instr = '0;
      repeat (4) @(negedge core_clk);
      reset = 0;
      chk(writeback_advance, 1'b1);
      foreach (rows[i]) begin
         mem(rows[i].k, rows[i].s, rows[i].w);
         repeat (rows[i].k == 2'h3 ? 1 : 2) @(negedge core_clk);
         chk(data_out_en, rows[i].en);
         if (rows[i].en) chk(data_out, rows[i].x);
      end
      alu(6'h02, 6'h36, 6'h34, 4'h2, 6'h25);
      for (int e = 0; e < 3; e++) begin
         next_issue;
         chk(issue.dest, 6'h02 + e);
         chk(issue.op, fcp_pkg::FCP_OP_SUB);
         chk(issue.opnd_a, `FCP_VAL_ONE);
         chk(issue.opnd_b, kv[e]);
      end
      chk(alu_busy, 1'b0);
      for (int c = 0; c < 16; c++) begin
         alu(6'h07, 6'h07, 6'h07, 4'h0, c[5:0]);
         next_issue;
         chk(issue.op, ops[4*c +: 4]);
         chk(issue.writes, ops[4*c +: 4] != 4'h0);
      end
      alu(6'h32, 6'h32, 6'h32, 4'h0, 6'h04);
      @(negedge core_clk);
      chk(alu_busy, 1'b0);
      alu(6'h2f, 6'h2f, 6'h2f, 4'h5, 6'h04);
      alu(6'h09, 6'h36, 6'h36, 4'h0, 6'h04);
      next_issue;
      mem(2'h1, 6'h09, 64'h0);
      stalled = 0;
      for (seen = 0; data_out_en !== 1'b1 && seen < 40; seen++) begin
         if (writeback_advance === 1'b0) stalled = 1;
         @(negedge core_clk);
      end
      chk(stalled, 1'b1);
      chk(data_out, {16'hfeed, 42'h0, 6'h09});
      test_done;
   end
endmodule // tb_top
